//--- ltr_regs.vh
`ifndef LTR_REGS_VH
`define LTR_REGS_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define LTR_NMOD 4
`define LTR_NFE 3
`define LTR_PER_W 16

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LTR_OFS_FE_SEL0 8'h00
`define LTR_OFS_FE_SEL1 8'h04
`define LTR_OFS_FE_SEL2 8'h08
`define LTR_OFS_SAMP_EN 8'h0c
`define LTR_OFS_GLB_EN 8'h10
`define LTR_OFS_PERIOD 8'h14
`define LTR_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// Front-end trigger select fields
// ----------------------------------------------------------------
`define LTR_SEL_W 9
`define LTR_SEL_SRC_LSB 0
`define LTR_SEL_SRC_MSB 1
`define LTR_SEL_MOD_LSB 2
`define LTR_SEL_MOD_MSB 3
`define LTR_SEL_RAMP_EN 4
`define LTR_SEL_DITH_EN 5
`define LTR_SEL_FLT_LSB 6
`define LTR_SEL_FLT_MSB 7
`define LTR_SEL_GAIN_EN 8

// Source codes
`define LTR_SRC_OFF 2'h0
`define LTR_SRC_EDGE_A 2'h1
`define LTR_SRC_EDGE_B 2'h2
`define LTR_SRC_FRAME 2'h3

// ----------------------------------------------------------------
// Global enable fields and reset values
// ----------------------------------------------------------------
`define LTR_GLB_MOD_LSB 0
`define LTR_GLB_FE_LSB 4
`define LTR_GLB_W 7

`define LTR_RST_SEL 9'h000
`define LTR_RST_SAMP 12'h000
`define LTR_RST_GLB 7'h00
`define LTR_RST_PER 16'h0000

`endif

//--- ltr_fe_mux.v
`default_nettype none

// One front-end trigger select: picks a modulator event and
// fans it out to ramp, dither and sync-rectifier ramp; gain step follows a filter threshold.
module ltr_fe_mux (
    input wire hclk,
    input wire hresetn,
    input wire [8:0] sel_cfg,
    input wire [3:0] rise_a,
    input wire [3:0] rise_b,
    input wire [3:0] frame,
    input wire [2:0] nl_step,
    output reg ramp_trig_q,
    output reg dither_trig_q,
    output reg sr_ramp_trig_q,
    output reg gain_step_q
);

`include "ltr_regs.vh"

    reg trig_d;
    wire [1:0] src = sel_cfg[`LTR_SEL_SRC_MSB:`LTR_SEL_SRC_LSB];
    wire [1:0] mod_idx = sel_cfg[`LTR_SEL_MOD_MSB:`LTR_SEL_MOD_LSB];
    wire [1:0] flt_idx = sel_cfg[`LTR_SEL_FLT_MSB:`LTR_SEL_FLT_LSB];
    wire flt_hit = (flt_idx == 2'h3) ? 1'b0 : nl_step[flt_idx];

    // Source selection
    always @* begin
        case (src)
            `LTR_SRC_EDGE_A: trig_d = rise_a[mod_idx];
            `LTR_SRC_EDGE_B: trig_d = rise_b[mod_idx];
            `LTR_SRC_FRAME: trig_d = frame[mod_idx];
            default: trig_d = 1'b0;
        endcase
    end

    // Registered trigger outputs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ramp_trig_q <= 1'b0;
            dither_trig_q <= 1'b0;
            sr_ramp_trig_q <= 1'b0;
            gain_step_q <= 1'b0;
        end else begin
            ramp_trig_q <= trig_d & sel_cfg[`LTR_SEL_RAMP_EN];
            dither_trig_q <= trig_d & sel_cfg[`LTR_SEL_DITH_EN];
            sr_ramp_trig_q <= trig_d;
            gain_step_q <= flt_hit & sel_cfg[`LTR_SEL_GAIN_EN];
        end
    end

endmodule // ltr_fe_mux

`default_nettype wire

//--- ltr_router.v
// Added by the designer: the address map and the AHB-Lite register port.
`default_nettype none

// Contract
// - Mux picks trigger for DAC ramp, dither
// - Same trigger drives sync-rectifier ramp module
// - Frame sync pulses at period start
// - Frame sync every period while running
// - Edge source fires only on real rise
// - Edges taken after fault stage
// - Held-low faulted output gives no trigger
// - Output mux, edge generator have no effect
// - Filter nonlinear thresholds drive gain steps
// - One enable bit per front-end/modulator pair
// - Sample enables cleared after reset
// - Any-to-any, many-to-one, one-to-many routing
// - Both A and B triggers, oversampling carried
// - Enabled pairs forward triggers automatically
// - One global enable register for all
// - Shared period register for all modulators
// - Run needs global and local enable
// - New period applies at period end
module ltr_router (
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Modulator side
    input wire [3:0] faulted_output_a,
    input wire [3:0] faulted_output_b,
    input wire [3:0] frame_sync,
    input wire [3:0] samp_trig_a,
    input wire [3:0] samp_trig_b,
    input wire [3:0] mod_local_en,
    input wire [3:0] mod_period_end,
    input wire [2:0] filter_nl_step,
    output reg [3:0] mod_run_q,
    output reg [63:0] mod_period_q,
    // Front-end side
    input wire [2:0] fe_local_en,
    output reg [2:0] fe_run_q,
    output wire [2:0] fe_ramp_trig,
    output wire [2:0] fe_dither_trig,
    output wire [2:0] sr_ramp_trig,
    output wire [2:0] fe_gain_step,
    output reg [2:0] fe_sample_trig_q
);

`include "ltr_regs.vh"

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // OR of all enabled modulator sample triggers for one front end
    function samp_or;
        input [3:0] en;
        input [3:0] ta;
        input [3:0] tb;
        begin
            samp_or = |(en & (ta | tb));
        end
    endfunction

    // Word-aligned offset match
    function ofs_is;
        input [7:0] a;
        input [7:0] ofs;
        begin
            ofs_is = (a[7:2] == ofs[7:2]);
        end
    endfunction

    // Writable bits of the word at one offset
    function [31:0] wr_mask;
        input [7:0] a;
        begin
            if (ofs_is(a, `LTR_OFS_FE_SEL0) | ofs_is(a, `LTR_OFS_FE_SEL1) | ofs_is(a, `LTR_OFS_FE_SEL2)) begin
                wr_mask = 32'h000001ff;
            end else if (ofs_is(a, `LTR_OFS_SAMP_EN)) begin
                wr_mask = 32'h00000fff;
            end else if (ofs_is(a, `LTR_OFS_GLB_EN)) begin
                wr_mask = 32'h0000007f;
            end else if (ofs_is(a, `LTR_OFS_PERIOD)) begin
                wr_mask = 32'h0000ffff;
            end else begin
                wr_mask = 32'h00000000;
            end
        end
    endfunction

    // Rising edge of a post-fault output on a running modulator
    function [3:0] rise_of;
        input [3:0] lvl;
        input [3:0] prev;
        input [3:0] run;
        begin
            rise_of = lvl & ~prev & run;
        end
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg [8:0] fe_sel_q [0:2];
    reg [11:0] samp_en_q;
    reg [6:0] glb_en_q;
    reg [15:0] period_q;

    reg wr_pend_q;
    reg [7:0] wr_addr_q;

    wire addr_ok = hsel & hready & htrans[1];
    wire wr_take = addr_ok & hwrite;
    wire rd_take = addr_ok & ~hwrite;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // AHB address phase capture
    // ----------------------------------------------------------------

    // Write address held into the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_take;
            if (wr_take) begin
                wr_addr_q <= haddr;
            end
        end
    end

    // Register writes in the data phase; unmapped writes ignored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fe_sel_q[0] <= `LTR_RST_SEL;
            fe_sel_q[1] <= `LTR_RST_SEL;
            fe_sel_q[2] <= `LTR_RST_SEL;
            samp_en_q <= `LTR_RST_SAMP;
            glb_en_q <= `LTR_RST_GLB;
            period_q <= `LTR_RST_PER;
        end else if (wr_pend_q) begin
            if (ofs_is(wr_addr_q, `LTR_OFS_FE_SEL0)) begin
                fe_sel_q[0] <= hwdata[8:0];
            end
            if (ofs_is(wr_addr_q, `LTR_OFS_FE_SEL1)) begin
                fe_sel_q[1] <= hwdata[8:0];
            end
            if (ofs_is(wr_addr_q, `LTR_OFS_FE_SEL2)) begin
                fe_sel_q[2] <= hwdata[8:0];
            end
            if (ofs_is(wr_addr_q, `LTR_OFS_SAMP_EN)) begin
                samp_en_q <= hwdata[11:0];
            end
            if (ofs_is(wr_addr_q, `LTR_OFS_GLB_EN)) begin
                glb_en_q <= hwdata[6:0];
            end
            if (ofs_is(wr_addr_q, `LTR_OFS_PERIOD)) begin
                period_q <= hwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // AHB read path
    // ----------------------------------------------------------------
    reg [31:0] rd_word;
    wire rd_fwd = wr_pend_q & ofs_is(wr_addr_q, haddr);
    wire [31:0] rd_mask = wr_mask(haddr);

    // Word currently held at the addressed offset
    always @* begin
        rd_word = 32'h00000000;
        if (ofs_is(haddr, `LTR_OFS_FE_SEL0)) begin
            rd_word = {23'h000000, fe_sel_q[0]};
        end else if (ofs_is(haddr, `LTR_OFS_FE_SEL1)) begin
            rd_word = {23'h000000, fe_sel_q[1]};
        end else if (ofs_is(haddr, `LTR_OFS_FE_SEL2)) begin
            rd_word = {23'h000000, fe_sel_q[2]};
        end else if (ofs_is(haddr, `LTR_OFS_SAMP_EN)) begin
            rd_word = {20'h00000, samp_en_q};
        end else if (ofs_is(haddr, `LTR_OFS_GLB_EN)) begin
            rd_word = {25'h0000000, glb_en_q};
        end else if (ofs_is(haddr, `LTR_OFS_PERIOD)) begin
            rd_word = {16'h0000, period_q};
        end else if (ofs_is(haddr, `LTR_OFS_STATUS)) begin
            rd_word = {25'h0000000, fe_run_q, mod_run_q};
        end
    end

    // Read data registered at the address phase edge; a write whose
    // data phase ends on that edge is merged in, so the read sees it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            if (rd_fwd) begin
                hrdata <= (rd_word & ~rd_mask) | (hwdata & rd_mask);
            end else begin
                hrdata <= rd_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Run enables and shared period
    // ----------------------------------------------------------------

    // Global AND local enable, one flop per module
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_run_q <= 4'h0;
            fe_run_q <= 3'h0;
        end else begin
            mod_run_q <= glb_en_q[3:0] & mod_local_en;
            fe_run_q <= glb_en_q[6:4] & fe_local_en;
        end
    end

    // Per-modulator period copy, loaded at that modulator's period end
    integer m;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_period_q <= 64'h0000000000000000;
        end else begin
            for (m = 0; m < 4; m = m + 1) begin
                if (mod_period_end[m]) begin
                    mod_period_q[m*16 +: 16] <= period_q;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Edge and frame trigger sources
    // ----------------------------------------------------------------
    reg [3:0] out_a_q;
    reg [3:0] out_b_q;

    // Previous level of the post-fault outputs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_a_q <= 4'h0;
            out_b_q <= 4'h0;
        end else begin
            out_a_q <= faulted_output_a;
            out_b_q <= faulted_output_b;
        end
    end

    // A held-low output never rises, so it never triggers
    wire [3:0] rise_a = rise_of(faulted_output_a, out_a_q, mod_run_q);
    wire [3:0] rise_b = rise_of(faulted_output_b, out_b_q, mod_run_q);
    // Frame sync passes for every period of a running modulator
    wire [3:0] frame_ok = frame_sync & mod_run_q;

    // ----------------------------------------------------------------
    // Front-end trigger selects and sample routing
    // ----------------------------------------------------------------
    genvar f;
    generate
        for (f = 0; f < 3; f = f + 1) begin : g_fe
            ltr_fe_mux u_mux (
                .hclk(hclk),
                .hresetn(hresetn),
                .sel_cfg(fe_sel_q[f]),
                .rise_a(rise_a),
                .rise_b(rise_b),
                .frame(frame_ok),
                .nl_step(filter_nl_step),
                .ramp_trig_q(fe_ramp_trig[f]),
                .dither_trig_q(fe_dither_trig[f]),
                .sr_ramp_trig_q(sr_ramp_trig[f]),
                .gain_step_q(fe_gain_step[f])
            );
        end
    endgenerate

    // Sample triggers: matrix column per front end, ORed
    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fe_sample_trig_q <= 3'h0;
        end else begin
            for (k = 0; k < 3; k = k + 1) begin
                fe_sample_trig_q[k] <= samp_or(samp_en_q[k*4 +: 4], samp_trig_a, samp_trig_b);
            end
        end
    end

endmodule // ltr_router

`default_nettype wire

//--- ltr_router_properties.sv
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module ltr_chk (
    input wire hclk,
    input wire hresetn,
    input wire [3:0] faulted_output_a,
    input wire [3:0] faulted_output_b,
    input wire [3:0] frame_sync,
    input wire [3:0] samp_trig_a,
    input wire [3:0] samp_trig_b,
    input wire [3:0] mod_local_en,
    input wire [3:0] mod_period_end,
    input wire [2:0] filter_nl_step,
    input wire [3:0] mod_run_q,
    input wire [63:0] mod_period_q,
    input wire [2:0] fe_local_en,
    input wire [2:0] fe_run_q,
    input wire [2:0] fe_ramp_trig,
    input wire [2:0] fe_dither_trig,
    input wire [2:0] sr_ramp_trig,
    input wire [2:0] fe_gain_step,
    input wire [2:0] fe_sample_trig_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] lvl_q;
    // Previous output levels for rise detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) lvl_q <= 8'h00;
        else lvl_q <= {faulted_output_b, faulted_output_a};
    end
    wire ev = (|({faulted_output_b, faulted_output_a} & ~lvl_q)) | (|frame_sync);
    sequence s_cause;
        $past(ev) && $past(|mod_run_q);
    endsequence
    property p_ramp; |fe_ramp_trig |-> s_cause; endproperty
    property p_dith; |fe_dither_trig |-> s_cause; endproperty
    property p_sr; |sr_ramp_trig |-> s_cause; endproperty
    property p_gain; |fe_gain_step |-> $past(|filter_nl_step); endproperty
    property p_samp; |fe_sample_trig_q |-> $past(|(samp_trig_a | samp_trig_b)); endproperty
    property p_mrun; (mod_run_q & ~$past(mod_local_en)) == 4'h0; endproperty
    property p_frun; (fe_run_q & ~$past(fe_local_en)) == 3'h0; endproperty
    property p_per; !$stable(mod_period_q) |-> $past(|mod_period_end); endproperty
    property p_rst; $rose(hresetn) |-> fe_sample_trig_q == 3'h0 && mod_run_q == 4'h0; endproperty
    a_ramp: assert property (p_ramp) else $error("ramp trigger without cause");
    a_dith: assert property (p_dith) else $error("dither trigger without cause");
    a_sr: assert property (p_sr) else $error("sync ramp trigger without cause");
    a_gain: assert property (p_gain) else $error("gain step without threshold");
    a_samp: assert property (p_samp) else $error("sample trigger without source");
    a_mrun: assert property (p_mrun) else $error("modulator runs without local enable");
    a_frun: assert property (p_frun) else $error("front end runs without local enable");
    a_per: assert property (p_per) else $error("period changed outside period end");
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule // ltr_chk
bind ltr_router ltr_chk i_ltr_chk (.hclk(hclk), .hresetn(hresetn), .faulted_output_a(faulted_output_a),
    .faulted_output_b(faulted_output_b), .frame_sync(frame_sync), .samp_trig_a(samp_trig_a),
    .samp_trig_b(samp_trig_b), .mod_local_en(mod_local_en), .mod_period_end(mod_period_end),
    .filter_nl_step(filter_nl_step), .mod_run_q(mod_run_q), .mod_period_q(mod_period_q),
    .fe_local_en(fe_local_en), .fe_run_q(fe_run_q), .fe_ramp_trig(fe_ramp_trig),
    .fe_dither_trig(fe_dither_trig), .sr_ramp_trig(sr_ramp_trig), .fe_gain_step(fe_gain_step),
    .fe_sample_trig_q(fe_sample_trig_q));
`default_nettype wire

//--- ltr_mod_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Modulator model
// ----------------------------------------------------------------
module ltr_mod_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] run,
    input wire logic [63:0] period,
    input wire logic [3:0] fault,
    output logic [3:0] out_a,
    output logic [3:0] out_b,
    output logic [3:0] frame,
    output logic [3:0] trig_a,
    output logic [3:0] trig_b,
    output logic [3:0] prd_end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q [4];
    // One period counter per modulator, idle while stopped
    always @(posedge hclk or negedge hresetn) begin
        for (int m = 0; m < 4; m++) begin
            if (!hresetn || !run[m]) begin
                cnt_q[m] <= 16'h0000;
                {out_a[m], out_b[m], frame[m], trig_a[m], trig_b[m], prd_end[m]} <= 6'h00;
            end else begin
                cnt_q[m] <= (cnt_q[m] >= period[m*16+:16]) ? 16'h0000 : cnt_q[m] + 16'h0001;
                frame[m] <= cnt_q[m] == 16'h0000;
                prd_end[m] <= cnt_q[m] == period[m*16+:16];
                out_a[m] <= !fault[m] && (cnt_q[m] == 16'h0001 || cnt_q[m] == 16'h0002);
                out_b[m] <= !fault[m] && cnt_q[m] == 16'h0006;
                trig_a[m] <= cnt_q[m] == 16'h0002 || cnt_q[m] == 16'h0004;
                trig_b[m] <= cnt_q[m] == 16'h0007;
            end
        end
    end
endmodule // ltr_mod_model
`default_nettype wire

//--- loop_trigger_router_test.sv
`default_nettype none
`include "ltr_regs.vh"
// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module loop_trigger_router_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, chk_on = 1'b0;
    logic [7:0] haddr = 8'h00, prev_q = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, seed = 32'hc78f, nseed = 32'hc78f, rdat;
    logic [3:0] mloc = 4'hf, fault = 4'h0, fa, fb, fs, ta, tb, pe, mrun;
    logic [2:0] floc = 3'h7, nl = 3'h0, frun, rp, dt, sr, gn, sp;
    logic [6:0] glb = 7'h00;
    logic [11:0] samp = 12'h000;
    logic [8:0] sel [3] = '{9'h0, 9'h0, 9'h0};
    logic [63:0] mper;
    logic [31:0] hrdata;
    wire hreadyout, hresp;
    logic [21:0] exp_q [$];
    int error_cnt = 0, n_compared = 0;
    ltr_router i_ltr_router (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .faulted_output_a(fa), .faulted_output_b(fb), .frame_sync(fs),
        .samp_trig_a(ta), .samp_trig_b(tb), .mod_local_en(mloc), .mod_period_end(pe), .filter_nl_step(nl),
        .mod_run_q(mrun), .mod_period_q(mper), .fe_local_en(floc), .fe_run_q(frun), .fe_ramp_trig(rp),
        .fe_dither_trig(dt), .sr_ramp_trig(sr), .fe_gain_step(gn), .fe_sample_trig_q(sp));
    ltr_mod_model i_ltr_mod_model (.hclk(hclk), .hresetn(hresetn), .run(mrun), .period(mper),
        .fault(fault), .out_a(fa), .out_b(fb), .frame(fs), .trig_a(ta), .trig_b(tb), .prd_end(pe));
    // Clock and watchdog
    initial forever #2.5 hclk = ~hclk;
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        summarize();
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Reference outputs for the cycle after the sampled inputs
    function automatic logic [21:0] expv();
        logic [2:0] erp, edt, esr, egn, esp;
        logic [3:0] run;
        logic ev;
        run = glb[3:0] & mloc;
        for (int f = 0; f < 3; f++) begin
            case (sel[f][1:0])
                `LTR_SRC_EDGE_A: ev = fa[sel[f][3:2]] & ~prev_q[sel[f][3:2]];
                `LTR_SRC_EDGE_B: ev = fb[sel[f][3:2]] & ~prev_q[4 + sel[f][3:2]];
                `LTR_SRC_FRAME: ev = fs[sel[f][3:2]];
                default: ev = 1'b0;
            endcase
            esr[f] = ev & run[sel[f][3:2]];
            erp[f] = esr[f] & sel[f][4];
            edt[f] = esr[f] & sel[f][5];
            egn[f] = sel[f][8] && sel[f][7:6] != 2'h3 && nl[sel[f][7:6]];
            esp[f] = |(samp[f*4+:4] & (ta | tb));
        end
        return {erp, edt, esr, egn, esp, run, glb[6:4] & floc};
    endfunction
    // Note expectations, drive threshold pulses
    always @(posedge hclk) begin
        if (chk_on) exp_q.push_back(expv());
        prev_q <= {fb, fa};
        nseed = xs(nseed);
        nl <= nseed[2:0];
    end
    // Compare outputs against the oldest note
    always @(negedge hclk) begin
        if (exp_q.size() > 0) chk({rp, dt, sr, gn, sp, mrun, frun}, exp_q.pop_front());
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        chk(64'(hresp), 64'h0);
    endtask
    // Write then read of one word, back to back
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic summarize();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk(64'(rdat), 64'h0);
        end
        wr_rd(`LTR_OFS_PERIOD, 32'hffff000c);
        chk(64'(rdat), 64'h0c);
        glb = 7'h7f;
        bus(1'b1, `LTR_OFS_GLB_EN, 32'(glb));
        repeat (40) @(posedge hclk);
        chk(mper, {4{16'h000c}});
        bus(1'b0, `LTR_OFS_STATUS, 32'h0);
        chk(64'(rdat), 64'h7f);
        for (int i = 0; i < 8; i++) begin
            chk_on <= 1'b0;
            @(posedge hclk);
            seed = xs(seed);
            samp = seed[11:0];
            fault <= (i == 5) ? seed[15:12] : 4'h0;
            if (i > 5) begin
                mloc <= seed[19:16];
                floc <= seed[22:20];
                glb = seed[29:23];
                bus(1'b1, `LTR_OFS_GLB_EN, 32'(glb));
            end
            if (i == 3) bus(1'b1, `LTR_OFS_PERIOD, 32'h00000010);
            for (int f = 0; f < 3; f++) begin
                seed = xs(seed);
                sel[f] = {seed[8:2], 2'((i + f) % 4)};
                bus(1'b1, 8'(4 * f), 32'(sel[f]));
            end
            bus(1'b1, `LTR_OFS_SAMP_EN, 32'(samp));
            repeat (4) @(posedge hclk);
            chk_on <= 1'b1;
            repeat (60) @(posedge hclk);
        end
        summarize();
    end
endmodule // loop_trigger_router_test
`default_nettype wire
